// ==== hdl/cbn_branch_map.svh ====
// opcode values, field positions, reset values and counts for the conditional branch decoder
`ifndef CBN_BRANCH_MAP_SVH
`define CBN_BRANCH_MAP_SVH

// upper byte of the instruction word selects the branch
`define CBN_OP_NEG_CLEAR   8'he7
`define CBN_OP_OVF_CLEAR   8'he5

// field positions inside the 16-bit instruction word
`define CBN_OPCODE_MSB     15
`define CBN_OPCODE_LSB     8
`define CBN_OFFSET_MSB     7
`define CBN_OFFSET_LSB     0

// four phases per instruction cycle, phase index of each step
`define CBN_PHASES         4
`define CBN_PH_DECODE      2'h0
`define CBN_PH_LITERAL     2'h1
`define CBN_PH_PROCESS     2'h2
`define CBN_PH_WRITE       2'h3

// instruction cycles for a failed and a taken branch
`define CBN_CYC_NOT_TAKEN  1
`define CBN_CYC_TAKEN      2

// reset values
`define CBN_PC_RST         0
`define CBN_OFFSET_RST     8'h00

`endif

// ==== hdl/cbn_pkg.sv ====
// types shared by the conditional branch decoder
package cbn_pkg;

    // one program word as presented by fetch
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] offset;
    } cbn_instr_t;

    // status flags that the branches test
    typedef struct packed {
        logic negative;
        logic overflow;
    } cbn_status_t;

    // which branch was decoded
    typedef enum logic [1:0] {
        kind_none,
        kind_neg_clear,
        kind_ovf_clear
    } cbn_kind_t;

    // instruction sequencing
    typedef enum logic [1:0] {
        st_wait,
        st_first,
        st_idle_cycle
    } cbn_state_t;

endpackage : cbn_pkg

// ==== hdl/cbn_qphase.sv ====
// four-phase instruction cycle generator driven by a clock divider
module cbn_qphase #(
    parameter int CLKS_PER_PHASE = 1
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // phase outputs
    output logic [1:0]      phase,
    output logic            adv
);

    localparam int CW = (CLKS_PER_PHASE > 1) ? $clog2(CLKS_PER_PHASE) : 1;

    logic [CW-1:0] div_cnt;

    // adv marks the last clock of the current phase
    assign adv = (div_cnt == CW'(CLKS_PER_PHASE - 1));

    // divider
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= '0;
        end else if (adv) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + CW'(1);
        end
    end

    // phase counter wraps Q4 back to Q1
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 2'h0;
        end else if (adv) begin
            phase <= phase + 2'h1;
        end
    end

endmodule : cbn_qphase

// ==== hdl/cbn_branch_core.sv ====
// decode and execute of the two relative branches on clear negative or clear overflow
// Operation
// - An instruction whose upper byte is e7 is branch_negative_clear, taken only when the negative flag is zero.
// - An instruction whose upper byte is e5 is branch_overflow_clear, taken only when the overflow flag is zero.
// - The low byte is a signed offset from -128 to 127.
// - The offset is doubled as a two's complement value so the displacement counts words.
// - The target is the branch address plus 2 plus the doubled offset, since the counter has already advanced.
// - Each branch is one word and takes one instruction cycle when not taken and two when taken.
`include "cbn_branch_map.svh"

module cbn_branch_core #(
    parameter int PC_W           = 21,
    parameter int CLKS_PER_PHASE = 1
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // instruction from fetch, held for the whole cycle
    input  wire logic                 issue_valid,
    input  wire cbn_pkg::cbn_instr_t  instr,
    input  wire logic [PC_W-1:0]      pc_inc,
    // status flags
    input  wire cbn_pkg::cbn_status_t status,
    // program counter write
    output logic                      pc_we,
    output logic [PC_W-1:0]           pc_target,
    // sequencing
    output logic [1:0]                q_phase,
    output logic                      accept,
    output logic                      taken,
    output logic                      idle_cycle,
    output logic                      done
);

    // ==========================================================
    // phase generation
    // ==========================================================
    logic adv;

    cbn_qphase #(
        .CLKS_PER_PHASE (CLKS_PER_PHASE)
    ) u_qphase (
        .clk   (clk),
        .rst_n (rst_n),
        .phase (q_phase),
        .adv   (adv)
    );

    wire end_q1 = adv && (q_phase == `CBN_PH_DECODE);
    wire end_q2 = adv && (q_phase == `CBN_PH_LITERAL);
    wire end_q3 = adv && (q_phase == `CBN_PH_PROCESS);
    wire end_q4 = adv && (q_phase == `CBN_PH_WRITE);

    // ==========================================================
    // decode
    // ==========================================================
    cbn_pkg::cbn_state_t state;
    cbn_pkg::cbn_kind_t  kind;
    cbn_pkg::cbn_kind_t  next_kind;
    logic [7:0]          offset;
    logic [PC_W-1:0]     pc_base;
    logic                cond_ok;

    // opcode match, anything else is left to other decoders
    always_comb begin
        next_kind = cbn_pkg::kind_none;
        if (instr.opcode == `CBN_OP_NEG_CLEAR) begin
            next_kind = cbn_pkg::kind_neg_clear;
        end else if (instr.opcode == `CBN_OP_OVF_CLEAR) begin
            next_kind = cbn_pkg::kind_ovf_clear;
        end
    end

    // only sampled at Q1 of a free cycle, so the idle cycle swallows any issue
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            kind   <= cbn_pkg::kind_none;
            accept <= 1'b0;
        end else begin
            accept <= 1'b0;
            if (end_q1 && state == cbn_pkg::st_wait) begin
                kind   <= issue_valid ? next_kind : cbn_pkg::kind_none;
                accept <= issue_valid && (next_kind != cbn_pkg::kind_none);
            end
        end
    end

    // Q2 reads the literal and the already advanced counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            offset  <= `CBN_OFFSET_RST;
            pc_base <= PC_W'(`CBN_PC_RST);
        end else if (end_q2 && state == cbn_pkg::st_first) begin
            offset  <= instr.offset;
            pc_base <= pc_inc;
        end
    end

    // ==========================================================
    // process: condition and target
    // ==========================================================
    logic [PC_W-1:0] disp;

    // sign extend then shift left by one: words, not bytes
    assign disp = {{(PC_W-9){offset[7]}}, offset, 1'b0};

    // flags are only read here, never written
    always_comb begin
        cond_ok = 1'b0;
        if (kind == cbn_pkg::kind_neg_clear) begin
            cond_ok = !status.negative;
        end else if (kind == cbn_pkg::kind_ovf_clear) begin
            cond_ok = !status.overflow;
        end
    end

    // target held from Q3 until the next taken branch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_target <= PC_W'(`CBN_PC_RST);
            taken     <= 1'b0;
        end else if (end_q3 && state == cbn_pkg::st_first) begin
            taken <= cond_ok;
            if (cond_ok) begin
                pc_target <= pc_base + disp;
            end
        end
    end

    // ==========================================================
    // sequencing
    // ==========================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= cbn_pkg::st_wait;
        end else begin
            unique case (state)
                cbn_pkg::st_wait: begin
                    if (end_q1 && issue_valid && next_kind != cbn_pkg::kind_none) begin
                        state <= cbn_pkg::st_first;
                    end
                end
                cbn_pkg::st_first: begin
                    if (end_q4) begin
                        state <= taken ? cbn_pkg::st_idle_cycle : cbn_pkg::st_wait;
                    end
                end
                cbn_pkg::st_idle_cycle: begin
                    if (end_q4) begin
                        state <= cbn_pkg::st_wait;
                    end
                end
            endcase
        end
    end

    // write in Q4 only when taken; the idle cycle is a pure bubble
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_we      <= 1'b0;
            done       <= 1'b0;
            idle_cycle <= 1'b0;
        end else begin
            pc_we <= end_q4 && state == cbn_pkg::st_first && taken;
            done  <= end_q4 && ((state == cbn_pkg::st_first && !taken)
                                || state == cbn_pkg::st_idle_cycle);
            if (end_q4 && state == cbn_pkg::st_first && taken) begin
                idle_cycle <= 1'b1;
            end else if (end_q4) begin
                idle_cycle <= 1'b0;
            end
        end
    end

    // ==========================================================
    // assertions
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // helper: phases since decode, and reference target
    logic [3:0]      ph_cnt;
    logic [PC_W-1:0] exp_target;
    logic [PC_W-1:0] tgt_delta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_cnt <= 4'h0;
        end else if (accept) begin
            ph_cnt <= 4'h2;
        end else if (adv && ph_cnt != 4'hf) begin
            ph_cnt <= ph_cnt + 4'h1;
        end
    end

    assign exp_target = pc_base - PC_W'(2) + PC_W'(2) + PC_W'($signed(offset) * 2);

    // distance the write moves the counter, kept apart from disp so a bad extension shows
    assign tgt_delta = pc_target - pc_base;

    property p_decode_neg;
        end_q1 && state == cbn_pkg::st_wait && issue_valid && instr.opcode == 8'he7
            |=> accept && kind == cbn_pkg::kind_neg_clear;
    endproperty
    a_decode_neg: assert property (p_decode_neg) else $error("negative-clear opcode not decoded");

    property p_decode_ovf;
        end_q1 && state == cbn_pkg::st_wait && issue_valid && instr.opcode == 8'he5
            |=> accept && kind == cbn_pkg::kind_ovf_clear;
    endproperty
    a_decode_ovf: assert property (p_decode_ovf) else $error("overflow-clear opcode not decoded");

    property p_sign;
        pc_we |-> tgt_delta[PC_W-1] == offset[7];
    endproperty
    a_sign: assert property (p_sign) else $error("offset not treated as signed");

    property p_double;
        pc_we |-> tgt_delta == PC_W'($signed(offset)) + PC_W'($signed(offset));
    endproperty
    a_double: assert property (p_double) else $error("displacement is not twice the offset");

    property p_target;
        pc_we |-> pc_target == exp_target;
    endproperty
    a_target: assert property (p_target) else $error("branch target wrong");

    property p_cycles;
        done |-> ph_cnt == (taken ? 4'h8 : 4'h4);
    endproperty
    a_cycles: assert property (p_cycles) else $error("branch took the wrong number of phases");

    property p_write_q4;
        pc_we |-> $past(q_phase) == 2'h3 && taken && idle_cycle;
    endproperty
    a_write_q4: assert property (p_write_q4) else $error("counter written outside Q4 of a taken branch");

    property p_no_write_not_taken;
        end_q4 && state == cbn_pkg::st_first && !taken |=> !pc_we && done;
    endproperty
    a_no_write_not_taken: assert property (p_no_write_not_taken) else $error("write on a failed branch");

    property p_idle_silent;
        idle_cycle |-> !accept && (!pc_we || $rose(idle_cycle));
    endproperty
    a_idle_silent: assert property (p_idle_silent) else $error("activity during the idle cycle");

    c_neg_taken:    cover property (accept && kind == cbn_pkg::kind_neg_clear ##[1:20] pc_we);
    c_ovf_taken:    cover property (accept && kind == cbn_pkg::kind_ovf_clear ##[1:20] pc_we);
    c_not_taken:    cover property (accept ##[1:20] done && !taken);
    c_back_offset:  cover property (pc_we && offset[7]);

endmodule : cbn_branch_core

// ==== testbench/testbench.sv ====
// self-checking testbench for the conditional relative branch decoder
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int PC_W = 21;

    // =====================================================================
    // signals
    logic                 clk;
    logic                 rst_n;
    logic                 issue_valid;
    cbn_pkg::cbn_instr_t  instr;
    logic [PC_W-1:0]      pc_inc;
    cbn_pkg::cbn_status_t status;
    logic                 pc_we;
    logic [PC_W-1:0]      pc_target;
    logic [1:0]           q_phase;
    logic                 accept;
    logic                 taken;
    logic                 idle_cycle;
    logic                 done;
    int                   errors;
    int                   comparisons;
    logic [PC_W-1:0]      last_tgt;
    logic                 last_tk;

    // one clock per phase keeps an instruction cycle at four clocks
    cbn_branch_core #(.PC_W(PC_W), .CLKS_PER_PHASE(1)) i_dut (
        .clk(clk), .rst_n(rst_n), .issue_valid(issue_valid), .instr(instr), .pc_inc(pc_inc),
        .status(status), .pc_we(pc_we), .pc_target(pc_target), .q_phase(q_phase), .accept(accept),
        .taken(taken), .idle_cycle(idle_cycle), .done(done)
    );

    // =====================================================================
    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // whole run is under two hundred clocks, so this is generous
    initial begin
        #20000;
        errors++;
        complete_run();
    end

    // =====================================================================
    // shared tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic complete_run;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    // issue one word in a free Q1 and watch nine clocks; hold keeps issuing into the bubble
    task automatic run_branch(input string name, input logic [7:0] op, input logic [7:0] off,
                              input logic [PC_W-1:0] pinc, input logic neg, input logic ovf,
                              input logic hold, input logic acc, input logic tk);
        int              k;
        int              guard;
        int              acc_n;
        int              we_at;
        int              done_at;
        int              idle_n;
        logic            tk_seen;
        logic [PC_W-1:0] exp_t;
        acc_n = 0;
        we_at = 0;
        done_at = 0;
        idle_n = 0;
        tk_seen = 1'b0;
        guard = 0;
        exp_t = pinc + {{12{off[7]}}, off, 1'b0};
        // align to the clock before Q1, since the phase counter free-runs
        do begin
            @(posedge clk);
            #1;
            guard++;
        end while (q_phase !== 2'h3 && guard < 16);
        @(posedge clk);
        issue_valid <= 1'b1;
        instr       <= '{opcode: op, offset: off};
        pc_inc      <= pinc;
        status      <= '{negative: neg, overflow: ovf};
        @(posedge clk);
        if (!hold) issue_valid <= 1'b0;
        for (k = 1; k <= 9; k++) begin
            #1;
            if (accept === 1'b1) acc_n++;
            if (pc_we === 1'b1) we_at = k;
            if (done === 1'b1 && done_at == 0) done_at = k;
            if (idle_cycle === 1'b1) idle_n++;
            if (k == 3) tk_seen = taken;
            @(posedge clk);
            if (k == 6) issue_valid <= 1'b0;
        end
        #1;
        // taken only moves on an accepted branch, otherwise it keeps the last verdict
        if (acc) last_tk = tk;
        check({name, " accepts"}, acc_n, {31'h0, acc});
        check({name, " taken"}, {31'h0, tk_seen}, {31'h0, last_tk});
        check({name, " done cycle"}, done_at, tk ? 8 : (acc ? 4 : 0));
        check({name, " write cycle"}, we_at, tk ? 4 : 0);
        check({name, " idle clocks"}, idle_n, tk ? 4 : 0);
        if (tk) last_tgt = exp_t;
        check({name, " target"}, {11'h0, pc_target}, {11'h0, last_tgt});
    endtask : run_branch

    // =====================================================================
    // scenarios
    task automatic test_reset;
        check("reset outputs", {25'h0, pc_we, accept, done, taken, idle_cycle, q_phase}, 32'h0);
        check("reset target", {11'h0, pc_target}, 32'h0);
    endtask : test_reset

    task automatic test_neg_clear;
        run_branch("neg max fwd", 8'he7, 8'h7f, 21'h000100, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        run_branch("neg set", 8'he7, 8'h12, 21'h000200, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    endtask : test_neg_clear

    task automatic test_ovf_clear;
        // most negative offset wraps below zero
        run_branch("ovf min back", 8'he5, 8'h80, 21'h000010, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
        run_branch("ovf set", 8'he5, 8'h05, 21'h000300, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    endtask : test_ovf_clear

    task automatic test_offsets;
        run_branch("off minus one", 8'he7, 8'hff, 21'h001000, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        run_branch("off zero", 8'he5, 8'h00, 21'h1ffffe, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    endtask : test_offsets

    task automatic test_foreign;
        logic [7:0] ops [4];
        ops = '{8'he6, 8'he4, 8'he3, 8'h67};
        foreach (ops[i]) begin
            run_branch("foreign", ops[i], 8'h20, 21'h000400, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        end
    endtask : test_foreign

    task automatic test_busy_issue;
        // issues held through the bubble must not start a second branch
        run_branch("busy issue", 8'he7, 8'h40, 21'h000500, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    endtask : test_busy_issue

    // =====================================================================
    // main sequence
    initial begin
        errors      = 0;
        comparisons = 0;
        last_tgt    = '0;
        last_tk     = 1'b0;
        rst_n       = 1'b0;
        issue_valid = 1'b0;
        instr       = '0;
        pc_inc      = '0;
        status      = '0;
        repeat (2) @(posedge clk);
        #1;
        test_reset();
        @(posedge clk);
        rst_n <= 1'b1;
        test_neg_clear();
        test_ovf_clear();
        test_offsets();
        test_foreign();
        test_busy_issue();
        complete_run();
    end

endmodule : testbench
